//--- verilog/fsp_map.svh
// offsets, field positions and fixed counts of the sweep profile block
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// register port offsets
`define FSP_OFS_PROG      4'h0
`define FSP_OFS_STATUS    4'h1
`define FSP_OFS_FREQ_LO   4'h2
`define FSP_OFS_FREQ_HI   4'h3

// widths
`define FSP_BUS_AW        4
`define FSP_WORD_W        16
`define FSP_HALF_W        12
`define FSP_FREQ_W        24
`define FSP_STEP_W        23
`define FSP_TICK_W        16

// programming word fields
`define FSP_ADDR_MSB      15
`define FSP_ADDR_LSB      12
`define FSP_DATA_MSB      11
`define FSP_FULL_BIT      11
`define FSP_INCSRC_BIT    5
`define FSP_STATUS_PULSE_SELECT_BIT   3
`define FSP_SYNCEN_BIT    2
`define FSP_DIR_BIT       11
`define FSP_STEPHI_MSB    10

// address field codes
`define FSP_CODE_CTRL     4'h0
`define FSP_CODE_COUNT    4'h1
`define FSP_CODE_STEP_LO  4'h2
`define FSP_CODE_STEP_HI  4'h3
`define FSP_CODE_START_LO 4'hc
`define FSP_CODE_START_HI 4'hd

// status word bits
`define FSP_ST_RUN_BIT    0
`define FSP_ST_EOS_BIT    1
`define FSP_ST_DONE_BIT   2
`define FSP_ST_SYNC_BIT   3

// sync pulse length in master clock periods, and unit increments
`define FSP_PULSE_CYCLES  3'h4
`define FSP_PULSE_ONE     3'h1
`define FSP_COUNT_ONE     12'h001
`define FSP_TICK_ONE      16'h0001

`endif

//--- verilog/fsp_pkg.sv
// types of the sweep profile block
`include "fsp_map.svh"

package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_RUN  = 2'b01,
    FSP_DONE = 2'b11
  } fsp_scan_t;

  typedef struct packed {
    logic full_word_load;
    logic increment_source_select;
    logic status_pulse_select;
    logic status_output_enable;
  } fsp_ctrl_t;

  typedef struct packed {
    logic [`FSP_BUS_AW-1:0] addr;
    logic [`FSP_WORD_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } fsp_bus_req_t;

  typedef struct packed {
    logic                   oe;
    logic                   level;
  } fsp_pin_t;

  typedef struct packed {
    fsp_ctrl_t              ctrl;
    logic [`FSP_FREQ_W-1:0] start_frequency;
    logic [`FSP_HALF_W-1:0] start_hold;
    logic                   start_hold_valid;
    logic [`FSP_STEP_W-1:0] step_mag;
    logic                   step_down;
    logic [`FSP_HALF_W-1:0] step_hold;
    logic                   step_hold_valid;
    logic [`FSP_HALF_W-1:0] step_count;
    logic [`FSP_HALF_W-1:0] steps_done;
    logic [`FSP_FREQ_W-1:0] freq;
    fsp_scan_t              scan;
    logic                   running;
    logic [2:0]             trig_sync;
    logic                   trig_level;
    logic [`FSP_TICK_W-1:0] tick;
    logic [2:0]             pulse_left;
    logic                   end_of_sweep;
    fsp_pin_t               pin;
    logic [`FSP_WORD_W-1:0] rd_data;
  } fsp_state_t;

endpackage

//--- verilog/fsp_regs.sv
// frequency sweep profile registers with scan stepping and status pin
//
// Overview of operation
// - D5 picks trigger-pin or automatic increments
// - sync select only matters when enabled
// - select one: high at end, low at restart
// - select zero: four-clock pulse per increment
// - enable bit drives pin, else released
// - full load off: halves update independently
// - codes 1100 and 1101 address start halves
// - scan first outputs start frequency
// - each increment adds signed step
// - scan ends after count steps
// - step magnitude 23 bits over two words
// - step high D11 sets sweep direction
// - count is twelve bits at code 0001
// - full load holds the low half until the high half is written
// - trigger rising edge starts the scan
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_regs
  import fsp_pkg::*;
#(
  parameter int unsigned AUTO_INTERVAL = 16
) (
  // clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  // register port
  input  wire fsp_bus_req_t           bus_req_in,
  output logic [`FSP_WORD_W-1:0]      rd_data_out,
  // external trigger pin
  input  wire logic                   trigger_pin_in,
  // status pin, three signals
  input  wire logic                   status_output_pin_in,
  output logic                        status_output_pin_out,
  output logic                        status_output_pin_oe_out,
  // present frequency word and scan state
  output logic [`FSP_FREQ_W-1:0]      freq_out,
  output logic                        scanning_out
);

  localparam logic [`FSP_TICK_W-1:0] TICK_LAST =
    `FSP_TICK_W'(AUTO_INTERVAL) - `FSP_TICK_ONE;

  fsp_state_t s_reg;
  fsp_state_t s_next;

  logic [`FSP_ADDR_MSB-`FSP_ADDR_LSB:0] code;
  logic [`FSP_HALF_W-1:0]               half;
  logic [`FSP_FREQ_W-1:0]               delta;
  logic [`FSP_HALF_W-1:0]               done_plus;
  logic                                 trig_stable;
  logic                                 trig_rise;
  logic                                 start_scan;
  logic                                 incr;
  logic                                 last_step;

  // the pin is only driven, never sampled
  logic                                 unused_pin;
  assign unused_pin = status_output_pin_in;

  always_comb begin
    s_next = s_reg;
    code   = bus_req_in.wdata[`FSP_ADDR_MSB:`FSP_ADDR_LSB];
    half   = bus_req_in.wdata[`FSP_DATA_MSB:0];
    delta  = {1'b0, s_reg.step_mag};

    // three-stage sampler; a change counts once stages two and three agree
    s_next.trig_sync = {s_reg.trig_sync[1:0], trigger_pin_in};
    trig_stable      = s_reg.trig_sync[1] == s_reg.trig_sync[2];
    trig_rise        = trig_stable & s_reg.trig_sync[1] & ~s_reg.trig_level;
    if (trig_stable) begin
      s_next.trig_level = s_reg.trig_sync[1];
    end

    // programming words; reserved and unused codes fall through
    if (bus_req_in.wr && bus_req_in.addr == `FSP_OFS_PROG) begin
      unique case (code)
        `FSP_CODE_CTRL: begin
          // reserved ones are not checked, only ignored
          s_next.ctrl.full_word_load          = bus_req_in.wdata[`FSP_FULL_BIT];
          s_next.ctrl.increment_source_select = bus_req_in.wdata[`FSP_INCSRC_BIT];
          s_next.ctrl.status_pulse_select     = bus_req_in.wdata[`FSP_STATUS_PULSE_SELECT_BIT];
          s_next.ctrl.status_output_enable    = bus_req_in.wdata[`FSP_SYNCEN_BIT];
          // a control write re-arms a finished scan
          if (s_reg.scan == FSP_DONE) begin
            s_next.scan = FSP_IDLE;
          end
        end
        `FSP_CODE_COUNT: begin
          s_next.step_count = half;
        end
        `FSP_CODE_STEP_LO: begin
          if (s_reg.ctrl.full_word_load) begin
            s_next.step_hold       = half;
            s_next.step_hold_valid = 1'b1;
          end else begin
            s_next.step_mag[`FSP_HALF_W-1:0] = half;
          end
        end
        `FSP_CODE_STEP_HI: begin
          s_next.step_down = bus_req_in.wdata[`FSP_DIR_BIT];
          s_next.step_mag[`FSP_STEP_W-1:`FSP_HALF_W] =
            bus_req_in.wdata[`FSP_STEPHI_MSB:0];
          if (s_reg.ctrl.full_word_load && s_reg.step_hold_valid) begin
            s_next.step_mag[`FSP_HALF_W-1:0] = s_reg.step_hold;
            s_next.step_hold_valid           = 1'b0;
          end
        end
        `FSP_CODE_START_LO: begin
          if (s_reg.ctrl.full_word_load) begin
            s_next.start_hold       = half;
            s_next.start_hold_valid = 1'b1;
          end else begin
            s_next.start_frequency[`FSP_HALF_W-1:0] = half;
          end
        end
        `FSP_CODE_START_HI: begin
          s_next.start_frequency[`FSP_FREQ_W-1:`FSP_HALF_W] = half;
          if (s_reg.ctrl.full_word_load && s_reg.start_hold_valid) begin
            s_next.start_frequency[`FSP_HALF_W-1:0] = s_reg.start_hold;
            s_next.start_hold_valid                 = 1'b0;
          end
        end
        default: begin
          s_next.scan = s_next.scan;
        end
      endcase
    end

    // scan sequencing
    start_scan = 1'b0;
    incr       = 1'b0;
    done_plus  = s_reg.steps_done + `FSP_COUNT_ONE;
    last_step  = done_plus >= s_reg.step_count;
    unique case (s_reg.scan)
      FSP_IDLE: begin
        if (trig_rise) begin
          start_scan          = 1'b1;
          s_next.scan         = FSP_RUN;
          s_next.freq         = s_reg.start_frequency;
          s_next.steps_done   = '0;
          s_next.tick         = '0;
          s_next.end_of_sweep = 1'b0;
        end
      end
      FSP_RUN: begin
        if (s_reg.ctrl.increment_source_select) begin
          incr = trig_rise;
        end else begin
          incr = s_reg.tick == TICK_LAST;
          s_next.tick = incr ? '0 : s_reg.tick + `FSP_TICK_ONE;
        end
        if (incr) begin
          // wraps modulo the word width, as a phase accumulator would
          s_next.freq = s_reg.step_down ? s_reg.freq - delta
                                        : s_reg.freq + delta;
          s_next.steps_done = done_plus;
          if (last_step) begin
            s_next.scan         = FSP_DONE;
            s_next.end_of_sweep = 1'b1;
          end
        end
      end
      FSP_DONE: begin
        s_next.freq = s_reg.freq;
      end
      default: begin
        // unused code: fall back to idle rather than lock up
        s_next.scan = FSP_IDLE;
      end
    endcase

    // sync pulse: loaded on every increment, counts down to zero
    if (incr) begin
      s_next.pulse_left = `FSP_PULSE_CYCLES;
    end else if (s_reg.pulse_left != '0) begin
      s_next.pulse_left = s_reg.pulse_left - `FSP_PULSE_ONE;
    end

    // a new scan drops a pulse still counting, before the pin level is formed
    if (start_scan) begin
      s_next.pulse_left = '0;
    end
    s_next.running = s_next.scan == FSP_RUN;

    s_next.pin.oe = s_next.ctrl.status_output_enable;
    if (!s_next.ctrl.status_output_enable) begin
      s_next.pin.level = 1'b0;
    end else if (s_next.ctrl.status_pulse_select) begin
      s_next.pin.level = s_next.end_of_sweep;
    end else begin
      s_next.pin.level = s_next.pulse_left != '0;
    end

    // read data stands one cycle after the strobe, zero otherwise
    s_next.rd_data = '0;
    if (bus_req_in.rd) begin
      unique case (bus_req_in.addr)
        `FSP_OFS_STATUS: begin
          s_next.rd_data[`FSP_ST_RUN_BIT]  = s_reg.scan == FSP_RUN;
          s_next.rd_data[`FSP_ST_EOS_BIT]  = s_reg.end_of_sweep;
          s_next.rd_data[`FSP_ST_DONE_BIT] = s_reg.scan == FSP_DONE;
          s_next.rd_data[`FSP_ST_SYNC_BIT] = s_reg.pin.level;
        end
        `FSP_OFS_FREQ_LO: begin
          s_next.rd_data[`FSP_HALF_W-1:0] = s_reg.freq[`FSP_HALF_W-1:0];
        end
        `FSP_OFS_FREQ_HI: begin
          s_next.rd_data[`FSP_HALF_W-1:0] =
            s_reg.freq[`FSP_FREQ_W-1:`FSP_HALF_W];
        end
        default: begin
          s_next.rd_data = '0;
        end
      endcase
    end

  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_out              = s_reg.rd_data;
  assign status_output_pin_out    = s_reg.pin.level;
  assign status_output_pin_oe_out = s_reg.pin.oe;
  assign freq_out                 = s_reg.freq;
  assign scanning_out             = s_reg.running;

endmodule

//--- tb/fsp_trig_host.sv
// host-side trigger pin driver for the sweep profile bench
`timescale 1ns/1ps
module fsp_trig_host (
  // clock and request
  input  wire logic clock_in,
  input  wire logic fire_in,
  // trigger pin
  output logic      trigger_pin_out
);
  logic [3:0] phase_reg = 4'h0;
  // four high then four low, long enough for the pin synchroniser
  always @(posedge clock_in) begin
    if (fire_in)
      phase_reg <= 4'h8;
    else if (phase_reg != 4'h0)
      phase_reg <= phase_reg - 4'h1;
  end
  assign trigger_pin_out = (phase_reg > 4'h4);
endmodule

//--- tb/fsp_regs_props.sv
// assertions on the sweep profile register ports
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_regs_props
  import fsp_pkg::*;
#(
  parameter int unsigned AUTO_INTERVAL = 16
) (
  input wire logic                   clock_in,
  input wire logic                   rst_n_in,
  input wire fsp_bus_req_t           bus_req_in,
  input wire logic [`FSP_WORD_W-1:0] rd_data_out,
  input wire logic                   trigger_pin_in,
  input wire logic                   status_output_pin_in,
  input wire logic                   status_output_pin_out,
  input wire logic                   status_output_pin_oe_out,
  input wire logic [`FSP_FREQ_W-1:0] freq_out,
  input wire logic                   scanning_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic                   sel_q;
  logic                   en_q;
  logic [`FSP_FREQ_W-1:0] freq_q;
  // shadow of the control bits, decoded from control words on the port
  always_ff @(posedge clock_in) begin
    freq_q <= freq_out;
    if (!rst_n_in)
      {sel_q, en_q} <= 2'b00;
    else if (bus_req_in.wr && bus_req_in.addr == 4'h0 && bus_req_in.wdata[15:12] == 4'h0)
      {sel_q, en_q} <= bus_req_in.wdata[3:2];
  end
  property p_oe; $stable(en_q)[*2] |-> status_output_pin_oe_out == en_q; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pulse;
    $past(scanning_out) && $changed(freq_out) && en_q && !sel_q
      |-> status_output_pin_out[*4] ##1 !status_output_pin_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("step pulse wrong");
  property p_lvl_set; $fell(scanning_out) && en_q && sel_q |-> ##[0:1] status_output_pin_out;
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("end level missing");
  property p_lvl_clr; $rose(scanning_out) && en_q && sel_q |-> ##[0:1] !status_output_pin_out;
  endproperty
  a_lvl_clr: assert property (p_lvl_clr) else $error("end level kept");
  property p_hold;
    !scanning_out && !$past(scanning_out) && !$past(bus_req_in.wr) |-> $stable(freq_out);
  endproperty
  a_hold: assert property (p_hold) else $error("frequency moved");
  property p_rd_none; !bus_req_in.rd |=> rd_data_out == 16'h0000; endproperty
  a_rd_none: assert property (p_rd_none) else $error("read data not cleared");
  property p_rd_lo; bus_req_in.rd && bus_req_in.addr == 4'h2
    |=> rd_data_out == {4'h0, freq_q[11:0]}; endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low read wrong");
  property p_rd_hi; bus_req_in.rd && bus_req_in.addr == 4'h3
    |=> rd_data_out == {4'h0, freq_q[23:12]}; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high read wrong");
  property p_rd_bad; bus_req_in.rd && (bus_req_in.addr > 4'h3 || bus_req_in.addr == 4'h0)
    |=> rd_data_out == 16'h0000; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
endmodule
bind fsp_regs fsp_regs_props #(.AUTO_INTERVAL(AUTO_INTERVAL)) i_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
  .rd_data_out(rd_data_out), .trigger_pin_in(trigger_pin_in),
  .status_output_pin_in(status_output_pin_in), .status_output_pin_out(status_output_pin_out),
  .status_output_pin_oe_out(status_output_pin_oe_out), .freq_out(freq_out),
  .scanning_out(scanning_out));

//--- tb/fsp_regs_bench.sv
// self-checking bench for the sweep profile registers
`timescale 1ns/1ps
module fsp_regs_bench;
  import fsp_pkg::*;
  logic         clock_in = 1'b0;
  logic         rst_n_in = 1'b0;
  fsp_bus_req_t req = '0;
  logic         fire = 1'b0;
  logic         trig, pin_o, pin_oe, scan, rd_pend = 1'b0;
  logic [15:0]  rd_data, e;
  logic [23:0]  freq, st, st2, f;
  logic [22:0]  sp;
  logic [15:0]  exp_q[$];
  int           fail_count = 0;
  int           total_checks = 0;
  always #5 clock_in = ~clock_in;
  fsp_trig_host i_host (.clock_in(clock_in), .fire_in(fire), .trigger_pin_out(trig));
  // released pin assumed pulled low
  fsp_regs #(.AUTO_INTERVAL(8)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .bus_req_in(req), .rd_data_out(rd_data), .trigger_pin_in(trig),
    .status_output_pin_in(pin_oe ? pin_o : 1'b0), .status_output_pin_out(pin_o),
    .status_output_pin_oe_out(pin_oe), .freq_out(freq), .scanning_out(scan));
  always @(posedge clock_in) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      total_checks++;
      if (rd_data !== e) begin
        fail_count++;
        $display("CHECK FAILED %0t read %h expected %h", $time, rd_data, e);
      end
    end
    rd_pend <= req.rd;
  end
  task automatic wr(input logic [15:0] d);
    @(posedge clock_in);
    req.addr <= 4'h0;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge clock_in);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(x);
    @(posedge clock_in);
    req.rd <= 1'b0;
  endtask
  task automatic chk_f(input logic [23:0] x);
    rd(4'h2, {4'h0, x[11:0]});
    rd(4'h3, {4'h0, x[23:12]});
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] x);
    total_checks++;
    if (got !== x) begin
      fail_count++;
      $display("CHECK FAILED %0t output %h expected %h", $time, got, x);
    end
  endtask
  task automatic pulse;
    @(posedge clock_in);
    fire <= 1'b1;
    @(posedge clock_in);
    fire <= 1'b0;
  endtask
  task automatic step_ext;
    pulse;
    repeat (12) @(posedge clock_in);
  endtask
  task automatic wait_scan(input logic v);
    int n;
    for (n = 0; n < 200 && scan !== v; n++) @(posedge clock_in);
    if (n == 200) begin
      fail_count++;
      $display("CHECK FAILED %0t scan state stuck", $time);
    end
  endtask
  function automatic logic [15:0] ctl(input logic fl, s, y, en);
    return {4'h0, fl, 5'b00011, s, 1'b1, y, en, 2'b11};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
  initial begin
    void'($urandom(23723));
    st = 24'($urandom);
    sp = 23'($urandom);
    st2 = {12'($urandom), st[11:0]};
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(4'h1, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(ctl(1'b1, 1'b1, 1'b0, 1'b1));
    wr({4'hc, st[11:0]});
    wr({4'hd, st[23:12]});
    wr({4'h2, sp[11:0]});
    wr({4'h3, 1'b0, sp[22:12]});
    wr({4'h1, 12'h003});
    wr({4'he, 12'hfff});
    wr({4'h9, 12'h0ff});
    chk_val({23'h00_0000, pin_oe}, 24'h00_0001);
    step_ext;
    chk_f(st);
    f = st;
    for (int k = 0; k < 3; k++) begin
      f = f + {1'b0, sp};
      step_ext;
      chk_f(f);
    end
    rd(4'h1, 16'h0006);
    step_ext;
    chk_f(f);
    wr(ctl(1'b0, 1'b0, 1'b1, 1'b1));
    wr({4'hd, st2[23:12]});
    wr({4'h3, 1'b1, sp[22:12]});
    wr({4'h1, 12'h002});
    pulse;
    wait_scan(1'b1);
    rd(4'h1, 16'h0001);
    wait_scan(1'b0);
    chk_f(st2 - {1'b0, sp} - {1'b0, sp});
    rd(4'h1, 16'h000e);
    chk_val({23'h00_0000, pin_o}, 24'h00_0001);
    chk_val(freq, st2 - {1'b0, sp} - {1'b0, sp});
    wr(ctl(1'b0, 1'b0, 1'b0, 1'b0));
    repeat (4) @(posedge clock_in);
    chk_val({23'h00_0000, pin_oe}, 24'h00_0000);
    chk_val({23'h00_0000, pin_o}, 24'h00_0000);
    chk_val({23'h00_0000, scan}, 24'h00_0000);
    stop_test;
  end
endmodule
